// >>> hdl/fpb_bus_if.sv
// Overview of operation
// - Reset low disables everything, floats outputs, aborts a running program.
// - Chip select high gives standby with outputs floating, whatever output drive.
// - Program or erase keeps running through standby.
// - Output drive high with chip selected floats the data outputs.
// - Output disable: wait driven idle on muxed parts, floated otherwise.
// - Sync-read-off set: select plus output drive low gives async read.
// - Async data valid only after all access conditions, last one counts.
// - Async reads work whatever the program supply level.
// - Toggling only the low four address bits reads the page faster.
// - Sync-read-off clear with latch strobe low starts a burst read.
// - First burst word comes after the latency count of clock edges.
// - Array bursts step the address each edge until burst length.
// - Non-array bursts repeat the same word until burst length.
// - Burst address latch point depends on the speed grade.
// - Start address picks the first word; following words in sequence.
// - Wrap bit chooses wrap inside the wordgroup or run on.
// - Unaligned burst crossing a wordline stalls once, latency minus one.
// - Select plus write strobe low is a write, sampled at first rise.
// - Muxed writes use the address latched at the address latch strobe rise.
// - Wait polarity configurable; asserted means data not yet valid.
`timescale 1ns/10ps
`include "fpb_consts.svh"

module fpb_bus_if #(
    parameter bit MUXED = 1'b1,
    parameter bit GRADE133 = 1'b0
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce_en,
    // Flash pins
    input wire fpb_pkg::fpb_ctl_t ctl_pins,
    input wire logic [`FPB_AW-1:0] addr_pins,
    input wire logic [`FPB_DW-1:0] dq_in,
    output logic [`FPB_DW-1:0] dq_out,
    output logic dq_oe,
    output logic wait_out,
    output logic wait_oe,
    // Read configuration
    input wire logic sync_read_off_bit,
    input wire logic burst_wrap_bit,
    input wire logic wait_high_true,
    input wire logic [1:0] burst_len,
    input wire logic [3:0] latency_count,
    input wire logic nonarray_sel,
    input wire logic [`FPB_DW-1:0] nonarray_data,
    // Program engine side
    input wire logic op_busy,
    input wire fpb_pkg::fpb_load_t array_load,
    output logic prog_abort,
    output fpb_pkg::fpb_wr_t wr_cmd,
    output fpb_pkg::fpb_state_t bus_state
);

    localparam int PW = 6 + `FPB_AW + `FPB_DW;
    localparam logic [3:0] ACC_CYC = 4'(`FPB_ACC_CYC);
    localparam logic [3:0] APA_CYC = 4'(`FPB_APA_CYC);

    // Next address inside or across the wordgroup
    function automatic logic [`FPB_AW-1:0] step_addr(
        input logic [`FPB_AW-1:0] a, input logic wrap);
        logic [`FPB_PAGE_BITS-1:0] low;
        low = a[`FPB_PAGE_BITS-1:0] + 1'b1;
        step_addr = wrap ? {a[`FPB_AW-1:`FPB_PAGE_BITS], low} : a + 1'b1;
    endfunction

    fpb_pkg::fpb_state_t state, next_state;
    fpb_pkg::fpb_ctl_t ctl_s, prev_ctl;
    logic [PW-1:0] pin_s;
    logic [`FPB_AW-1:0] addr_s, bus_addr, eff_addr, prev_eff, hold_addr;
    logic [`FPB_AW-1:0] cur_addr, mem_addr;
    logic [`FPB_DW-1:0] dq_s, mem_q, word;
    logic [3:0] acc_cnt, lat_cnt, stall_cnt;
    logic [4:0] word_cnt;
    logic aread_valid, got_edge, eowl_armed;

    // All pins pass two flops before use
    fpb_sync #(.W(PW), .RST({`FPB_CTL_RST, `FPB_ADDR_RST, `FPB_DQ_RST}))
    u_pin_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce_en(ce_en),
        .d_async({ctl_pins, addr_pins, dq_in}),
        .d_sync(pin_s)
    );

    fpb_word_mem u_mem (
        .clk_sys(clk_sys),
        .ce_en(ce_en),
        .load(array_load),
        .rd_addr(mem_addr),
        .rd_data(mem_q)
    );

    // Pin decode, active high
    wire rst_ok = ctl_s.reset_in_low;
    wire cs = !ctl_s.chip_select_low;
    wire oe = !ctl_s.output_drive_low;
    wire we = !ctl_s.write_strobe_low;
    wire adv = !ctl_s.address_latch_strobe_low;
    assign ctl_s = pin_s[PW-1:PW-6];
    assign addr_s = pin_s[`FPB_AW+`FPB_DW-1:`FPB_DW];
    assign dq_s = pin_s[`FPB_DW-1:0];

    // Edges seen on the synchronised pins
    wire bclk_rise = ctl_s.burst_clk && !prev_ctl.burst_clk;
    wire adv_rise = !adv && !prev_ctl.address_latch_strobe_low;
    wire adv_fall = adv && prev_ctl.address_latch_strobe_low;
    wire ce_rise = !cs && !prev_ctl.chip_select_low;
    wire we_rise = !we && !prev_ctl.write_strobe_low;

    // Muxed parts take the whole address off the low data pins
    assign bus_addr = MUXED ? dq_s[`FPB_AW-1:0] : addr_s;
    assign eff_addr = adv ? bus_addr : hold_addr;
    wire wrap_on = !burst_wrap_bit;

    // Burst address latch point per speed grade
    wire sync_latch = GRADE133 ? adv_rise : (adv_rise || bclk_rise);
    wire lat_done = bclk_rise && ({1'b0, lat_cnt} + 5'h01 >= {1'b0, latency_count});
    wire burst_done = (burst_len == `FPB_BL_8 && word_cnt == 5'h08) ||
                      (burst_len == `FPB_BL_16 && word_cnt == 5'h10);
    wire out_edge = bclk_rise && ((state == fpb_pkg::ST_SLAT && lat_done) ||
        (state == fpb_pkg::ST_SBURST && stall_cnt == 4'h0 && !burst_done));
    wire adv_step = out_edge && !nonarray_sel;
    wire cross_wl = wrap_on ? 1'b0 : (cur_addr[`FPB_PAGE_BITS-1:0] == 4'hF);
    wire eowl_hit = adv_step && cross_wl && eowl_armed;
    wire aread_new = (state != fpb_pkg::ST_AREAD) || (eff_addr != prev_eff);
    wire page_hit = (state == fpb_pkg::ST_AREAD) && aread_valid &&
        (eff_addr[`FPB_AW-1:`FPB_PAGE_BITS] ==
         prev_eff[`FPB_AW-1:`FPB_PAGE_BITS]);
    wire wr_evt = (state == fpb_pkg::ST_WRITE) && (we_rise || ce_rise);
    wire sync_st = (state == fpb_pkg::ST_SLAT) || (state == fpb_pkg::ST_SBURST);
    wire read_drive = (state == fpb_pkg::ST_AREAD) || sync_st;
    // A stall left over from a cut burst must not hold wait outside bursts
    wire wait_act = (state == fpb_pkg::ST_SADDR) ||
        (state == fpb_pkg::ST_SLAT) ||
        (state == fpb_pkg::ST_SBURST && stall_cnt != 4'h0);

    // Status and ID reads bypass the array; no supply level gates reads
    assign word = nonarray_sel ? nonarray_data : mem_q;
    assign mem_addr = sync_st ? cur_addr : eff_addr;

    // Bus operation decode, reset first, then select
    always_comb
    begin
        next_state = state;
        if (!rst_ok)
            next_state = fpb_pkg::ST_RESET;
        else if (!cs)
            next_state = fpb_pkg::ST_STANDBY;
        else if (we && !oe)
            next_state = fpb_pkg::ST_WRITE;
        else if (!oe || we)
            next_state = fpb_pkg::ST_DISABLE;
        else if (sync_read_off_bit)
            next_state = fpb_pkg::ST_AREAD;
        else if (adv_fall)
            next_state = fpb_pkg::ST_SADDR;
        else
        begin
            case (state)
                fpb_pkg::ST_SADDR:
                    next_state = sync_latch ? fpb_pkg::ST_SLAT : state;
                fpb_pkg::ST_SLAT:
                    next_state = lat_done ? fpb_pkg::ST_SBURST : state;
                fpb_pkg::ST_SBURST:
                    next_state = state;
                default:
                    next_state = adv ? fpb_pkg::ST_SADDR : fpb_pkg::ST_DISABLE;
            endcase
        end
    end

    // State, edge history and address hold
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state <= fpb_pkg::ST_RESET;
            prev_ctl <= `FPB_CTL_RST;
            hold_addr <= `FPB_ADDR_RST;
        end
        else if (ce_en)
        begin
            state <= next_state;
            prev_ctl <= ctl_s;
            if (adv && cs)
                hold_addr <= bus_addr;
        end
    end

    // Asynchronous access timer; page hits use the shorter time
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            acc_cnt <= 4'h0;
            aread_valid <= 1'b0;
            prev_eff <= `FPB_ADDR_RST;
        end
        else if (ce_en)
        begin
            prev_eff <= eff_addr;
            if (next_state != fpb_pkg::ST_AREAD)
            begin
                acc_cnt <= 4'h0;
                aread_valid <= 1'b0;
            end
            else if (aread_new)
            begin
                acc_cnt <= page_hit ? APA_CYC : ACC_CYC;
                aread_valid <= 1'b0;
            end
            else if (acc_cnt != 4'h0)
            begin
                acc_cnt <= acc_cnt - 4'h1;
                aread_valid <= (acc_cnt == 4'h1);
            end
        end
    end

    // Burst latch, latency and word stepping
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cur_addr <= `FPB_ADDR_RST;
            lat_cnt <= 4'h0;
            stall_cnt <= 4'h0;
            word_cnt <= 5'h00;
            got_edge <= 1'b0;
            eowl_armed <= 1'b0;
        end
        else if (ce_en)
        begin
            if (state == fpb_pkg::ST_SADDR)
            begin
                if (GRADE133 && bclk_rise)
                begin
                    cur_addr <= bus_addr;
                    got_edge <= 1'b1;
                end
                if (sync_latch)
                begin
                    if (!(GRADE133 && got_edge))
                        cur_addr <= bus_addr;
                    lat_cnt <= (bclk_rise || got_edge) ? 4'h1 : 4'h0;
                    eowl_armed <= (bus_addr[`FPB_PAGE_BITS-1:0] != 4'h0);
                end
                word_cnt <= 5'h00;
                stall_cnt <= 4'h0;
            end
            else
            begin
                got_edge <= 1'b0;
                if (state == fpb_pkg::ST_SLAT && bclk_rise && !lat_done)
                    lat_cnt <= lat_cnt + 4'h1;
                if (state == fpb_pkg::ST_SBURST && bclk_rise &&
                    stall_cnt != 4'h0)
                    stall_cnt <= stall_cnt - 4'h1;
                if (out_edge && burst_len != `FPB_BL_CONT)
                    word_cnt <= word_cnt + 5'h01;
                if (adv_step)
                    cur_addr <= step_addr(cur_addr, wrap_on);
                if (eowl_hit)
                begin
                    stall_cnt <= latency_count - 4'h1;
                    eowl_armed <= 1'b0;
                end
            end
        end
    end

    // Pin outputs, all registered
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            dq_out <= `FPB_DQ_RST;
            dq_oe <= 1'b0;
            wait_out <= 1'b0;
            wait_oe <= 1'b0;
        end
        else if (ce_en)
        begin
            dq_oe <= read_drive;
            if ((state == fpb_pkg::ST_AREAD && aread_valid) || out_edge)
                dq_out <= word;
            // Reset and standby float wait; disable depends on variant
            wait_oe <= (read_drive || state == fpb_pkg::ST_SADDR ||
                (state == fpb_pkg::ST_DISABLE && MUXED));
            wait_out <= wait_high_true ? wait_act : !wait_act;
        end
    end

    // Handoff to command logic and program engine
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wr_cmd <= '0;
            prog_abort <= 1'b0;
            bus_state <= fpb_pkg::ST_RESET;
        end
        else if (ce_en)
        begin
            wr_cmd.valid <= wr_evt;
            wr_cmd.addr <= MUXED ? eff_addr : bus_addr;
            wr_cmd.data <= dq_s;
            // Standby never aborts; only a reset entry does
            prog_abort <= !rst_ok && state != fpb_pkg::ST_RESET && op_busy;
            bus_state <= state;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst || !ce_en);

    chk_reset_float: assert property (!rst_ok |=> ##1 (!dq_oe && !wait_oe))
        else $error("outputs driven during reset");
    chk_abort_pulse: assert property ((!rst_ok && state != fpb_pkg::ST_RESET
        && op_busy) |=> prog_abort)
        else $error("no abort on reset entry");
    chk_standby_float: assert property ((rst_ok && !cs) |=> ##1 !dq_oe)
        else $error("data driven in standby");
    chk_disable_hiz: assert property ((rst_ok && cs && !oe) |=> ##1 !dq_oe)
        else $error("data driven with output drive high");
    chk_wait_disable: assert property ((rst_ok && cs && !oe && !we) |=> ##1
        (wait_oe == MUXED && (!MUXED || wait_out == !wait_high_true)))
        else $error("wait wrong in output disable");
    chk_async_delay: assert property ($rose(state == fpb_pkg::ST_AREAD) |->
        !aread_valid [*2])
        else $error("async data valid too early");
    chk_burst_wrap: assert property ((adv_step && wrap_on) |=>
        cur_addr[`FPB_AW-1:`FPB_PAGE_BITS] ==
        $past(cur_addr[`FPB_AW-1:`FPB_PAGE_BITS]))
        else $error("wrapped burst left its wordgroup");
    chk_nonarray_hold: assert property ((out_edge && nonarray_sel) |=>
        $stable(cur_addr))
        else $error("non-array burst stepped address");
    chk_burst_len: assert property ((burst_len == `FPB_BL_8) |->
        word_cnt <= 5'h08)
        else $error("burst ran past eight words");
    chk_eowl_once: assert property (eowl_hit |=> !eowl_armed &&
        stall_cnt == latency_count - 4'h1)
        else $error("wordline stall not loaded");
    chk_write_pulse: assert property (wr_cmd.valid |->
        $past(state) == fpb_pkg::ST_WRITE)
        else $error("write captured outside write state");

    cov_async_read: cover property ($rose(aread_valid));
    cov_burst_word: cover property (out_edge ##[1:50] out_edge);
    cov_eowl_stall: cover property (eowl_hit);
    cov_write: cover property (wr_cmd.valid);

endmodule

// >>> hdl/fpb_consts.svh
`ifndef FPB_CONSTS_SVH
`define FPB_CONSTS_SVH

// System clock period
`define FPB_CLK_NS 20

// Initial asynchronous access time and page access time
`define FPB_T_ACC_NS 100
`define FPB_T_APA_NS 25
`define FPB_ACC_CYC ((`FPB_T_ACC_NS + `FPB_CLK_NS - 1) / `FPB_CLK_NS)
`define FPB_APA_CYC ((`FPB_T_APA_NS + `FPB_CLK_NS - 1) / `FPB_CLK_NS)

// Widths of the word store and the bus
`define FPB_AW 8
`define FPB_DW 16
`define FPB_PAGE_BITS 4

// Burst length codes
`define FPB_BL_8 2'h0
`define FPB_BL_16 2'h1
`define FPB_BL_CONT 2'h2

// Reset values: reset pin low, other control pins idle high, burst clock low
`define FPB_CTL_RST 6'h1E
`define FPB_DQ_RST 16'h0000
`define FPB_ADDR_RST 8'h00

`endif

// >>> hdl/fpb_pkg.sv
`include "fpb_consts.svh"

package fpb_pkg;

    // Bus states, one-hot
    typedef enum logic [7:0] {
        ST_RESET   = 8'h01,
        ST_STANDBY = 8'h02,
        ST_DISABLE = 8'h04,
        ST_AREAD   = 8'h08,
        ST_SADDR   = 8'h10,
        ST_SLAT    = 8'h20,
        ST_SBURST  = 8'h40,
        ST_WRITE   = 8'h80
    } fpb_state_t;

    // Control pins as they arrive at the package balls
    typedef struct packed {
        logic reset_in_low;
        logic chip_select_low;
        logic output_drive_low;
        logic write_strobe_low;
        logic address_latch_strobe_low;
        logic burst_clk;
    } fpb_ctl_t;

    // Captured bus write handed to the command logic
    typedef struct packed {
        logic valid;
        logic [`FPB_AW-1:0] addr;
        logic [`FPB_DW-1:0] data;
    } fpb_wr_t;

    // Word store load port from the program engine
    typedef struct packed {
        logic we;
        logic [`FPB_AW-1:0] addr;
        logic [`FPB_DW-1:0] data;
    } fpb_load_t;

endpackage

// >>> hdl/fpb_sync.sv
`timescale 1ns/10ps
`include "fpb_consts.svh"

module fpb_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce_en,
    // Data
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] d_sync
);

    logic [W-1:0] meta;

    // Two stages; the first is read only by the second
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            meta <= RST;
            d_sync <= RST;
        end
        else if (ce_en)
        begin
            meta <= d_async;
            d_sync <= meta;
        end
    end

endmodule

// >>> hdl/fpb_word_mem.sv
`timescale 1ns/10ps
`include "fpb_consts.svh"

module fpb_word_mem (
    // Clock, enable
    input wire logic clk_sys,
    input wire logic ce_en,
    // Load port
    input wire fpb_pkg::fpb_load_t load,
    // Read port, data registered
    input wire logic [`FPB_AW-1:0] rd_addr,
    output logic [`FPB_DW-1:0] rd_data
);

    logic [`FPB_DW-1:0] store [0:(1<<`FPB_AW)-1];

    // No reset on the array: contents survive a bus reset
    always_ff @(posedge clk_sys)
    begin
        if (ce_en)
        begin
            if (load.we)
                store[load.addr] <= load.data;
            rd_data <= store[rd_addr];
        end
    end

endmodule

// >>> dv/fpb_host_model.sv
`timescale 1ns/10ps
`include "fpb_consts.svh"

module fpb_host_model (
    // Clock
    input wire logic clk_sys,
    // Device data drive
    input wire logic [`FPB_DW-1:0] dq_out,
    input wire logic dq_oe,
    // Host pins
    output fpb_pkg::fpb_ctl_t ctl_pins,
    output logic [`FPB_AW-1:0] addr_pins,
    output logic [`FPB_DW-1:0] dq_in
);
    logic [`FPB_DW-1:0] host_data = 16'h0000;
    logic host_oe = 1'b0;
    logic [`FPB_DW-1:0] float_pat = 16'h5A5A;

    // Power up with the reset pin low and the burst clock still
    initial
    begin
        ctl_pins = `FPB_CTL_RST;
        addr_pins = `FPB_ADDR_RST;
    end

    // A released bus toggles so a stale word can never pass for data
    always @(posedge clk_sys)
        float_pat <= ~float_pat;
    assign dq_in = dq_oe ? dq_out : (host_oe ? host_data : float_pat);

    // Control pins move together just after an edge
    task automatic pins(input logic cs, input logic oe, input logic we,
                        input logic adv, input logic [`FPB_AW-1:0] a);
        @(posedge clk_sys);
        ctl_pins.chip_select_low <= cs;
        ctl_pins.output_drive_low <= oe;
        ctl_pins.write_strobe_low <= we;
        ctl_pins.address_latch_strobe_low <= adv;
        addr_pins <= a;
    endtask

    // Read with write strobe high and burst clock left where it is
    task automatic rd(input logic [`FPB_AW-1:0] a);
        pins(1'b0, 1'b0, 1'b1, 1'b0, a);
    endtask

    // Deselect between cycles so reads and writes never run together
    task automatic deselect();
        pins(1'b1, 1'b1, 1'b1, 1'b1, addr_pins);
        repeat (3) @(posedge clk_sys);
    endtask

    // Write: data held well past the strobe rise
    task automatic wr(input logic [`FPB_AW-1:0] a,
                      input logic [`FPB_DW-1:0] d);
        pins(1'b0, 1'b1, 1'b1, 1'b1, a);
        host_data <= d;
        host_oe <= 1'b1;
        pins(1'b0, 1'b1, 1'b0, 1'b1, a);
        repeat (4) @(posedge clk_sys);
        pins(1'b0, 1'b1, 1'b1, 1'b1, a);
        repeat (3) @(posedge clk_sys);
        host_oe <= 1'b0;
        deselect();
    endtask

    task automatic bclk(input logic v);
        @(posedge clk_sys);
        ctl_pins.burst_clk <= v;
    endtask

    // Recovery time is waited out before any further cycle
    task automatic rst_pin(input logic v);
        @(posedge clk_sys);
        ctl_pins.reset_in_low <= v;
        if (v)
            repeat (8) @(posedge clk_sys);
    endtask
endmodule

// >>> dv/fpb_bus_if_tb_top.sv
`timescale 1ns/10ps
`include "fpb_consts.svh"

module fpb_bus_if_tb_top;
    logic [3:0] lat = 4'h3;
    logic ce_en = 1'b1;
    logic wait_high_true = 1'b1;
    logic [1:0] burst_len = `FPB_BL_8;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic sync_read_off_bit = 1'b1;
    logic burst_wrap_bit = 1'b0;
    logic nonarray_sel = 1'b0;
    logic op_busy = 1'b0;
    logic [`FPB_DW-1:0] nonarray_data = 16'h0C5A;
    fpb_pkg::fpb_load_t array_load = '0;
    fpb_pkg::fpb_ctl_t ctl_pins;
    logic [`FPB_AW-1:0] addr_pins;
    logic [`FPB_DW-1:0] dq_in;
    logic [`FPB_DW-1:0] dq_out;
    logic dq_oe, wait_out, wait_oe, prog_abort;
    fpb_pkg::fpb_wr_t wr_cmd;
    fpb_pkg::fpb_wr_t last_wr = '0;
    fpb_pkg::fpb_state_t bus_state;
    int bad_count = 0;
    int samples_checked = 0;
    int abort_cnt = 0;
    int wr_cnt = 0;

    fpb_bus_if #(.MUXED(1'b0), .GRADE133(1'b0)) u_fpb_bus_if (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ce_en(ce_en),
        .ctl_pins(ctl_pins), .addr_pins(addr_pins), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .wait_out(wait_out),
        .wait_oe(wait_oe), .sync_read_off_bit(sync_read_off_bit),
        .burst_wrap_bit(burst_wrap_bit), .wait_high_true(wait_high_true),
        .burst_len(burst_len), .latency_count(lat),
        .nonarray_sel(nonarray_sel), .nonarray_data(nonarray_data),
        .op_busy(op_busy), .array_load(array_load),
        .prog_abort(prog_abort), .wr_cmd(wr_cmd), .bus_state(bus_state));

    fpb_host_model u_fpb_host_model (
        .clk_sys(clk_sys), .dq_out(dq_out), .dq_oe(dq_oe),
        .ctl_pins(ctl_pins), .addr_pins(addr_pins), .dq_in(dq_in));

    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    // Pulses are counted here so no scenario can miss a one-cycle output
    always @(posedge clk_sys)
    begin
        if (prog_abort === 1'b1)
            abort_cnt <= abort_cnt + 1;
        if (wr_cmd.valid === 1'b1)
        begin
            wr_cnt <= wr_cnt + 1;
            last_wr <= wr_cmd;
        end
    end

    function automatic logic [15:0] word(input logic [7:0] a);
        return {~a, a};
    endfunction

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask

    // Let the edge's register updates land before looking
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic results();
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic t_standby();
        int n0;
        u_fpb_host_model.pins(1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
        op_busy <= 1'b1;
        n0 = abort_cnt;
        settle(8);
        chk_bit(dq_oe, 1'b0);
        chk_bit(wait_oe, 1'b0);
        chk_word(16'(bus_state), 16'(fpb_pkg::ST_STANDBY));
        chk_word(16'(abort_cnt - n0), 16'h0000);
        @(posedge clk_sys);
        op_busy <= 1'b0;
    endtask

    task automatic t_aread();
        u_fpb_host_model.rd(8'h37);
        settle(10);
        chk_bit(dq_oe, 1'b1);
        chk_word(dq_out, word(8'h37));
        u_fpb_host_model.rd(8'h3A);
        // Clock enable low must freeze the old word and the state
        ce_en <= 1'b0;
        settle(6);
        chk_word(dq_out, word(8'h37));
        chk_word(16'(bus_state), 16'(fpb_pkg::ST_AREAD));
        @(posedge clk_sys);
        ce_en <= 1'b1;
        settle(7);
        chk_word(dq_out, word(8'h3A));
        u_fpb_host_model.pins(1'b0, 1'b1, 1'b1, 1'b0, 8'h3A);
        settle(6);
        chk_bit(dq_oe, 1'b0);
        chk_bit(wait_oe, 1'b0);
        u_fpb_host_model.deselect();
    endtask

    task automatic t_write();
        int n0;
        n0 = wr_cnt;
        u_fpb_host_model.wr(8'h44, 16'hBEEF);
        settle(2);
        chk_word(16'(wr_cnt - n0), 16'h0001);
        chk_word(16'(last_wr.addr), 16'h0044);
        chk_word(last_wr.data, 16'hBEEF);
    endtask

    // Words are taken at each burst clock rise where wait shows valid
    task automatic t_burst(input logic [7:0] start, input logic wrap,
                           input logic na, input logic stall_exp);
        logic [7:0] a;
        int got, stalls, first;
        a = start;
        got = 0;
        stalls = 0;
        first = 0;
        @(posedge clk_sys);
        sync_read_off_bit <= 1'b0;
        burst_wrap_bit <= wrap;
        nonarray_sel <= na;
        u_fpb_host_model.rd(start);
        settle(4);
        for (int i = 1; i <= 20; i++)
        begin
            u_fpb_host_model.bclk(1'b1);
            settle(5);
            if (got < 8 && wait_oe === 1'b1 && wait_out === !wait_high_true)
            begin
                chk_word(dq_out, na ? nonarray_data : word(a));
                if (!na)
                    a = wrap ? a + 8'h01 : {a[7:4], a[3:0] + 4'h1};
                if (first == 0)
                    first = i;
                got++;
            end
            else if (got > 0 && got < 8)
                stalls++;
            u_fpb_host_model.bclk(1'b0);
            settle(3);
        end
        chk_word(16'(got), 16'h0008);
        chk_bit(first >= 2 && first <= int'(lat) + 1, 1'b1);
        chk_bit(stalls > 0, stall_exp);
        chk_bit(stalls <= int'(lat) - 1, 1'b1);
        u_fpb_host_model.deselect();
        @(posedge clk_sys);
        sync_read_off_bit <= 1'b1;
        nonarray_sel <= 1'b0;
    endtask

    task automatic t_reset();
        int n0;
        u_fpb_host_model.rd(8'h50);
        settle(10);
        @(posedge clk_sys);
        op_busy <= 1'b1;
        n0 = abort_cnt;
        u_fpb_host_model.rst_pin(1'b0);
        settle(8);
        chk_word(16'(abort_cnt - n0), 16'h0001);
        chk_bit(dq_oe, 1'b0);
        chk_bit(wait_oe, 1'b0);
        chk_word(16'(bus_state), 16'(fpb_pkg::ST_RESET));
        @(posedge clk_sys);
        op_busy <= 1'b0;
        u_fpb_host_model.deselect();
        u_fpb_host_model.rst_pin(1'b1);
    endtask

    // Main sequence: fill the word store, then walk the bus modes
    initial
    begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int a = 0; a < 256; a++)
        begin
            @(posedge clk_sys);
            array_load <= {1'b1, 8'(a), word(8'(a))};
        end
        @(posedge clk_sys);
        array_load <= '0;
        u_fpb_host_model.rst_pin(1'b1);
        t_standby();
        t_aread();
        t_write();
        t_burst(8'h1E, 1'b0, 1'b0, 1'b0);
        // Longer latency stretches the wordline stall as well
        lat <= 4'h4;
        t_burst(8'h1E, 1'b1, 1'b0, 1'b1);
        // Low-true wait and an endless burst on the status word
        wait_high_true <= 1'b0;
        burst_len <= `FPB_BL_CONT;
        t_burst(8'h25, 1'b0, 1'b1, 1'b0);
        t_reset();
        results();
    end

    // Whole run needs about 1000 cycles; this cuts a hang short
    initial
    begin
        repeat (6000) @(posedge clk_sys);
        bad_count++;
        results();
    end
endmodule
